// file: rtl/atpwc_defines.svh
`ifndef ATPWC_DEFINES_SVH
`define ATPWC_DEFINES_SVH
`define ATPWC_OFS_CTRL_A 8'hb0
`define ATPWC_OFS_CTRL_B 8'hb1
`define ATPWC_OFS_COUNT 8'hb2
`define ATPWC_OFS_CMP_A 8'hb3
`define ATPWC_OFS_CMP_B 8'hb4
`define ATPWC_OFS_GEN_CTRL 8'hb5
`define ATPWC_OFS_ASYNC_STAT 8'hb6
`define ATPWC_MASK_CTRL_A 8'hf3
`define ATPWC_MASK_CTRL_B 8'h0f
`define ATPWC_COMA_HI 7
`define ATPWC_COMA_LO 6
`define ATPWC_COMB_HI 5
`define ATPWC_COMB_LO 4
`define ATPWC_WGM_HI 1
`define ATPWC_WGM_LO 0
`define ATPWC_WGM2_BIT 3
`define ATPWC_CS_HI 2
`define ATPWC_CS_LO 0
`define ATPWC_ASYNC_BIT 0
`define ATPWC_PSR_BIT 0
`define ATPWC_RST_BYTE 8'h00
`define ATPWC_MAX 8'hff
`define ATPWC_BOTTOM 8'h00
`endif

// file: rtl/atpwc_pkg.sv
`default_nettype none
package atpwc_pkg;
  typedef enum logic [4:0] {
    K_NORMAL = 5'b00001,
    K_CTC = 5'b00010,
    K_FAST = 5'b00100,
    K_PHASE = 5'b01000,
    K_RSVD = 5'b10000
  } atpwc_kind_t;
  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } atpwc_dir_t;
endpackage
`default_nettype wire

// file: rtl/atpwc_top.sv
`include "atpwc_defines.svh"
`default_nettype none
module atpwc_top
  import atpwc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic osc_pin_in,
  input wire logic dir_a,
  input wire logic dir_b,
  output logic compare_out_a,
  output logic compare_out_a_oe_n,
  output logic compare_out_b,
  output logic compare_out_b_oe_n,
  output logic osc_detach,
  output logic overflow_flag
);

  // three-bit mode decode into one-hot kind
  function automatic atpwc_kind_t kind_of(input logic [2:0] m);
    atpwc_kind_t k;
    k = K_RSVD;
    unique case (m)
      3'h0: k = K_NORMAL;
      3'h2: k = K_CTC;
      3'h3, 3'h7: k = K_FAST;
      3'h1, 3'h5: k = K_PHASE;
      3'h4, 3'h6: k = K_RSVD;
    endcase
    return k;
  endfunction

  // prescaler low bits that must be all ones for a tap
  function automatic logic [9:0] tap_mask(input logic [2:0] cs);
    logic [9:0] m;
    m = 10'h000;
    unique case (cs)
      3'h0, 3'h1: m = 10'h000;
      3'h2: m = 10'h007;
      3'h3: m = 10'h01f;
      3'h4: m = 10'h03f;
      3'h5: m = 10'h07f;
      3'h6: m = 10'h0ff;
      3'h7: m = 10'h3ff;
    endcase
    return m;
  endfunction

  // next output level of one compare channel on a timer tick
  function automatic logic wave_next(
    input logic oc,
    input logic [1:0] com,
    input atpwc_kind_t k,
    input logic tog_ok,
    input logic match,
    input logic at_top,
    input logic at_bot,
    input logic up,
    input logic cmp_is_top,
    input logic sub_top
  );
    logic n;
    logic spec;
    logic hit;
    logic bot_evt;
    n = oc;
    spec = cmp_is_top & com[1] & ((k == K_FAST) | (k == K_PHASE));
    hit = match & ~spec;
    bot_evt = (spec & sub_top) ? at_top : at_bot;
    unique case (k)
      K_NORMAL, K_CTC:
      begin
        if (hit && com == 2'b01)
          n = ~oc;
        else if (hit && com[1])
          n = com[0];
      end
      K_FAST:
      begin
        if (com[1] && bot_evt)
          n = ~com[0];
        if (hit && com[1])
          n = com[0];
        else if (hit && com[0] && tog_ok)
          n = ~oc;
      end
      K_PHASE:
      begin
        if (hit && com[1])
          n = up ? com[0] : ~com[0];
        else if (hit && com[0] && tog_ok)
          n = ~oc;
        if (spec && at_top)
          n = ~com[0];
      end
      K_RSVD: n = oc;
    endcase
    return n;
  endfunction

  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic async_sel_q;
  logic [7:0] cmp_a_buf_q;
  logic [7:0] cmp_b_buf_q;
  logic [7:0] cmp_a_q;
  logic [7:0] cmp_b_q;
  logic [7:0] cnt_q;
  atpwc_dir_t dir_q;
  logic block_q;
  logic [9:0] pre_q;
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic oc_a_q;
  logic oc_b_q;
  logic oe_n_a_q;
  logic oe_n_b_q;
  logic detach_q;
  logic ovf_q;
  logic [7:0] rdata_q;

  logic [1:0] com_a;
  logic [1:0] com_b;
  logic [2:0] cs;
  logic [2:0] mode;
  atpwc_kind_t kind;
  logic [7:0] top;
  logic src_tick;
  logic timer_tick;
  logic psr_wr;
  logic cnt_wr;
  logic at_top;
  logic at_bot;
  logic match_a;
  logic match_b;
  logic conn_a;
  logic conn_b;
  logic ovf_evt;

  // field extraction and mode decode
  assign com_a = ctrl_a_q[`ATPWC_COMA_HI:`ATPWC_COMA_LO];
  assign com_b = ctrl_a_q[`ATPWC_COMB_HI:`ATPWC_COMB_LO];
  assign cs = ctrl_b_q[`ATPWC_CS_HI:`ATPWC_CS_LO];
  assign mode = {ctrl_b_q[`ATPWC_WGM2_BIT],
                 ctrl_a_q[`ATPWC_WGM_HI:`ATPWC_WGM_LO]};
  assign kind = kind_of(mode);
  assign top = (mode[2] || kind == K_CTC) ? cmp_a_q : `ATPWC_MAX;
  assign at_top = (cnt_q == top);
  assign at_bot = (cnt_q == `ATPWC_BOTTOM);
  assign match_a = (cnt_q == cmp_a_q) && !block_q;
  assign match_b = (cnt_q == cmp_b_q) && !block_q;
  assign psr_wr = wr_en && (addr == `ATPWC_OFS_GEN_CTRL)
                  && wdata[`ATPWC_PSR_BIT];
  assign cnt_wr = wr_en && (addr == `ATPWC_OFS_COUNT);

  // source clock: every cycle, or rising oscillator edges when async
  assign src_tick = async_sel_q ? (osc_s2_q & ~osc_s3_q) : 1'b1;
  assign timer_tick = src_tick && (cs != 3'h0)
    && ((pre_q & tap_mask(cs)) == tap_mask(cs));

  // channel connection; reserved or gated toggle codes stay off
  assign conn_a = (com_a != 2'b00) && !((kind == K_FAST || kind == K_PHASE)
    && com_a == 2'b01 && !ctrl_b_q[`ATPWC_WGM2_BIT]);
  assign conn_b = (com_b != 2'b00) && !((kind == K_FAST || kind == K_PHASE)
    && com_b == 2'b01);

  // overflow point per mode
  always_comb
  begin
    ovf_evt = 1'b0;
    unique case (kind)
      K_NORMAL, K_CTC: ovf_evt = timer_tick && cnt_q == `ATPWC_MAX;
      K_FAST: ovf_evt = timer_tick && at_top;
      K_PHASE: ovf_evt = timer_tick && at_bot && dir_q == DIR_DOWN;
      K_RSVD: ovf_evt = 1'b0;
    endcase
  end

  // control and status registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_a_q <= `ATPWC_RST_BYTE;
      ctrl_b_q <= `ATPWC_RST_BYTE;
      async_sel_q <= 1'b0;
      cmp_a_buf_q <= `ATPWC_RST_BYTE;
      cmp_b_buf_q <= `ATPWC_RST_BYTE;
    end
    else if (wr_en)
    begin
      if (addr == `ATPWC_OFS_CTRL_A)
        ctrl_a_q <= wdata & `ATPWC_MASK_CTRL_A;
      if (addr == `ATPWC_OFS_CTRL_B)
        ctrl_b_q <= wdata & `ATPWC_MASK_CTRL_B;
      if (addr == `ATPWC_OFS_ASYNC_STAT)
        async_sel_q <= wdata[`ATPWC_ASYNC_BIT];
      if (addr == `ATPWC_OFS_CMP_A)
        cmp_a_buf_q <= wdata;
      if (addr == `ATPWC_OFS_CMP_B)
        cmp_b_buf_q <= wdata;
    end
  end

  // oscillator pin synchroniser and edge stage
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end
    else
    begin
      osc_s1_q <= osc_pin_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // prescaler, restarted by software strobe
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pre_q <= 10'h000;
    else if (psr_wr)
      pre_q <= 10'h000;
    else if (src_tick)
      pre_q <= pre_q + 10'h001;
  end

  // compare buffers: immediate, or at TOP in both PWM modes
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp_a_q <= `ATPWC_RST_BYTE;
      cmp_b_q <= `ATPWC_RST_BYTE;
    end
    else if ((kind == K_NORMAL || kind == K_CTC || kind == K_RSVD)
             || (timer_tick && at_top && kind == K_FAST)
             || (timer_tick && at_top && kind == K_PHASE
                 && dir_q == DIR_UP))
    begin
      cmp_a_q <= cmp_a_buf_q;
      cmp_b_q <= cmp_b_buf_q;
    end
  end

  // counter and direction
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= `ATPWC_RST_BYTE;
      dir_q <= DIR_UP;
      block_q <= 1'b0;
    end
    else if (cnt_wr)
    begin
      cnt_q <= wdata;
      block_q <= 1'b1;
    end
    else if (timer_tick)
    begin
      block_q <= 1'b0;
      unique case (kind)
        K_NORMAL: cnt_q <= cnt_q + 8'h01;
        K_CTC, K_FAST: cnt_q <= at_top ? `ATPWC_BOTTOM
                                       : cnt_q + 8'h01;
        K_PHASE:
        begin
          if (dir_q == DIR_UP && at_top)
          begin
            dir_q <= DIR_DOWN;
            cnt_q <= cnt_q - 8'h01;
          end
          else if (dir_q == DIR_DOWN && at_bot)
          begin
            dir_q <= DIR_UP;
            cnt_q <= cnt_q + 8'h01;
          end
          else if (dir_q == DIR_UP)
            cnt_q <= cnt_q + 8'h01;
          else
            cnt_q <= cnt_q - 8'h01;
        end
        K_RSVD: cnt_q <= cnt_q;
      endcase
    end
  end

  // waveform outputs, pin drivers and overflow strobe
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oc_a_q <= 1'b0;
      oc_b_q <= 1'b0;
      oe_n_a_q <= 1'b1;
      oe_n_b_q <= 1'b1;
      detach_q <= 1'b0;
      ovf_q <= 1'b0;
    end
    else
    begin
      if (timer_tick)
      begin
        oc_a_q <= wave_next(oc_a_q, com_a, kind, ctrl_b_q[`ATPWC_WGM2_BIT],
          match_a, at_top, at_bot, dir_q == DIR_UP, cmp_a_q == top,
          1'b0);
        oc_b_q <= wave_next(oc_b_q, com_b, kind, 1'b0, match_b, at_top,
          at_bot, dir_q == DIR_UP, cmp_b_q == top,
          1'b1);
      end
      oe_n_a_q <= !(conn_a && dir_a);
      oe_n_b_q <= !(conn_b && dir_b);
      detach_q <= async_sel_q;
      ovf_q <= ovf_evt;
    end
  end

  // read port, data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= `ATPWC_RST_BYTE;
    else if (!rd_en)
      rdata_q <= `ATPWC_RST_BYTE;
    else
    begin
      unique case (addr)
        `ATPWC_OFS_CTRL_A: rdata_q <= ctrl_a_q;
        `ATPWC_OFS_CTRL_B: rdata_q <= ctrl_b_q;
        `ATPWC_OFS_COUNT: rdata_q <= cnt_q;
        `ATPWC_OFS_CMP_A: rdata_q <= cmp_a_buf_q;
        `ATPWC_OFS_CMP_B: rdata_q <= cmp_b_buf_q;
        `ATPWC_OFS_ASYNC_STAT: rdata_q <= {7'h00, async_sel_q};
        default: rdata_q <= `ATPWC_RST_BYTE;
      endcase
    end
  end

  assign rdata = rdata_q;
  assign compare_out_a = oc_a_q;
  assign compare_out_b = oc_b_q;
  assign compare_out_a_oe_n = oe_n_a_q;
  assign compare_out_b_oe_n = oe_n_b_q;
  assign osc_detach = detach_q;
  assign overflow_flag = ovf_q;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_pc_peak;
    kind == K_PHASE && timer_tick && dir_q == DIR_UP && at_top && !cnt_wr;
  endsequence

  sequence s_pc_fall;
    dir_q == DIR_DOWN && cnt_q == $past(top) - 8'h01;
  endsequence

  a_sync_source: assert property (!async_sel_q && cs == 3'h1
    && kind == K_NORMAL && !cnt_wr |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("sync source not ticking");
  a_pin_detach: assert property (async_sel_q |=> osc_detach)
    else $error("osc pins not detached");
  a_div8_tap: assert property (cs == 3'h2 && timer_tick |->
    pre_q[2:0] == 3'h7)
    else $error("divide by 8 tap misaligned");
  a_psr_restart: assert property (psr_wr |=> pre_q == 10'h000)
    else $error("prescaler not restarted");
  a_stop_sel: assert property (cs == 3'h0 |-> !timer_tick)
    else $error("stopped timer ticked");
  a_drive_off: assert property (com_a == 2'b00 |=> compare_out_a_oe_n)
    else $error("disconnected A drives pin");
  a_ctc_wrap: assert property (kind == K_CTC && timer_tick && at_top
    && !cnt_wr |=> cnt_q == `ATPWC_BOTTOM)
    else $error("ctc did not clear");
  a_normal_ovf: assert property (kind == K_NORMAL && timer_tick
    && cnt_q == `ATPWC_MAX && !cnt_wr |=> overflow_flag
    && cnt_q == `ATPWC_BOTTOM)
    else $error("normal overflow missing");
  a_nonpwm_clear: assert property (kind == K_NORMAL && timer_tick
    && match_a && com_a == 2'b10 |=> !compare_out_a)
    else $error("A not cleared on match");
  a_fast_b_set: assert property (kind == K_FAST && timer_tick && at_bot
    && !match_b && com_b == 2'b10 && cmp_b_q != top |=> compare_out_b)
    else $error("B not set at bottom");
  a_pc_turn: assert property (s_pc_peak |=> s_pc_fall)
    else $error("phase mode did not turn at top");
endmodule
`default_nettype wire

// file: sim/atpwc_xtal_model.sv
`default_nettype none
module atpwc_xtal_model #(
  parameter int HALF_NS = 40
) (
  input wire logic run,
  input wire logic detach,
  output logic osc_pin_in,
  input wire logic out_a,
  input wire logic oe_n_a,
  input wire logic out_b,
  input wire logic oe_n_b,
  output logic pin_a,
  output logic pin_b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial osc_pin_in = 1'b0;
  initial pin_a = 1'b0;
  initial pin_b = 1'b0;
  // crystal swings only while the pins are handed over
  always
  begin
    #(HALF_NS);
    if (run && detach)
      osc_pin_in = ~osc_pin_in;
    else
      osc_pin_in = 1'b0;
  end
  // released pin floats away from its last level
  always @(out_a, oe_n_a)
    pin_a = oe_n_a ? ~pin_a : out_a;
  always @(out_b, oe_n_b)
    pin_b = oe_n_b ? ~pin_b : out_b;
endmodule
`default_nettype wire

// file: sim/testbench.sv
`include "atpwc_defines.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic dir_a = 1'b0;
  logic dir_b = 1'b0;
  logic xtal_on = 1'b0;
  logic [7:0] rdata;
  logic [7:0] d, e;
  logic osc_pin_in, oa, oan, ob, obn, osc_detach, overflow_flag;
  logic pin_a, pin_b, p;
  logic [15:0] ha, hb;
  int n, f, i;
  int n_mismatch = 0;
  int checks_done = 0;
  int tap[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  int md[5] = '{0, 1, 3, 5, 7};
  int per[5] = '{256, 510, 256, 18, 10};
  logic [1:0] dcb[5] = '{2'b11, 2'b11, 2'b10, 2'b10, 2'b11};
  logic [2:0] dmd[5] = '{3'd3, 3'd1, 3'd3, 3'd1, 3'd7};
  logic [7:0] dpa[5] = '{8'h80, 8'h40, 8'hff, 8'hff, 8'h09};
  logic [7:0] dpb[5] = '{8'h80, 8'h40, 8'hff, 8'hff, 8'h04};
  int dwin[5] = '{512, 1020, 512, 1020, 500};
  logic [15:0] dea[5] = '{16'd256, 16'd256, 16'd512, 16'd1020, 16'd500};
  logic [15:0] deb[5] = '{16'd256, 16'd764, 16'd512, 16'd1020, 16'd300};

  // free running system clock
  always #4 clk_sys = ~clk_sys;

  atpwc_top uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .osc_pin_in(osc_pin_in),
    .dir_a(dir_a), .dir_b(dir_b), .compare_out_a(oa),
    .compare_out_a_oe_n(oan), .compare_out_b(ob),
    .compare_out_b_oe_n(obn), .osc_detach(osc_detach),
    .overflow_flag(overflow_flag)
  );
  atpwc_xtal_model xm (
    .run(xtal_on), .detach(osc_detach), .osc_pin_in(osc_pin_in),
    .out_a(oa), .oe_n_a(oan), .out_b(ob), .oe_n_b(obn),
    .pin_a(pin_a), .pin_b(pin_b)
  );

  // verdict and end of run
  task complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // compare seen against expected
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // register bus cycles
  task wr(input logic [7:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    v = rdata;
    @(posedge clk_sys);
  endtask
  task cfg(input logic [1:0] ca, input logic [1:0] cb, input logic [2:0] m,
           input logic [2:0] cs, input logic [7:0] pa, input logic [7:0] pb);
    wr(`ATPWC_OFS_CMP_A, pa);
    wr(`ATPWC_OFS_CMP_B, pb);
    wr(`ATPWC_OFS_CTRL_A, {ca, cb, 2'b00, m[1:0]});
    wr(`ATPWC_OFS_CTRL_B, {4'h0, m[2], cs});
  endtask

  // cycles to first event and between first and second
  task gap(input bit ovf, output int f, output int n);
    logic q, c;
    int k, j;
    k = 0;
    f = 0;
    n = 0;
    q = pin_a;
    for (j = 0; j < 6000 && k < 2; j++)
    begin
      @(posedge clk_sys);
      #1;
      c = ovf ? overflow_flag : pin_a;
      if (k == 0) f++;
      if (k == 1) n++;
      if (ovf ? (c === 1'b1) : (c !== q)) k++;
      q = c;
    end
    if (k < 2)
    begin
      n_mismatch++;
      $display("ERROR %0t no event seen", $time);
      complete_run;
    end
  endtask

  // high cycles of both pins over a window
  task duty(input int win);
    ha = 0;
    hb = 0;
    repeat (win)
    begin
      @(posedge clk_sys);
      #1;
      ha = ha + pin_a;
      hb = hb + pin_b;
    end
  endtask

  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(`ATPWC_OFS_CTRL_A, d);
    chk(d, `ATPWC_RST_BYTE);
    chk(oan, 1'b1);
    chk(obn, 1'b1);
    wr(`ATPWC_OFS_CTRL_A, 8'hff);
    rd(`ATPWC_OFS_CTRL_A, d);
    chk(d, 8'hf3);
    rd(8'hc0, d);
    chk(d, 8'h00);
    dir_a <= 1'b1;
    dir_b <= 1'b1;
    for (i = 1; i < 8; i++)
    begin
      cfg(2'b01, 2'b01, 3'd2, i[2:0], 8'h00, 8'h00);
      gap(0, f, n);
      gap(0, f, n);
      chk(n, tap[i]);
      chk(pin_b, pin_a);
    end
    repeat (300) @(posedge clk_sys);
    wr(`ATPWC_OFS_GEN_CTRL, 8'h01);
    gap(0, f, n);
    chk(f > 1000 && f <= 1024, 1'b1);
    wr(`ATPWC_OFS_CTRL_B, 8'h00);
    p = pin_a;
    repeat (2100) @(posedge clk_sys);
    chk(pin_a, p);
    dir_a <= 1'b0;
    for (i = 2; i < 4; i++)
    begin
      cfg(i[1:0], i[1:0], 3'd0, 3'd1, 8'h10, 8'h10);
      repeat (300) @(posedge clk_sys);
      chk(oa, i == 3);
      chk(pin_b, i == 3);
      chk(oan, i == 2);
      dir_a <= 1'b1;
    end
    for (i = 0; i < 5; i++)
    begin
      cfg(2'b00, 2'b00, md[i][2:0], 3'd1, 8'h09, 8'h00);
      gap(1, f, n);
      chk(n, per[i]);
    end
    cfg(2'b00, 2'b00, 3'd4, 3'd1, 8'h09, 8'h00);
    rd(`ATPWC_OFS_COUNT, d);
    repeat (20) @(posedge clk_sys);
    rd(`ATPWC_OFS_COUNT, e);
    chk(e, d);
    for (i = 0; i < 5; i++)
    begin
      cfg(2'b10, dcb[i], dmd[i], 3'd1, dpa[i], dpb[i]);
      repeat (1100) @(posedge clk_sys);
      duty(dwin[i]);
      chk(ha, dea[i]);
      chk(hb, deb[i]);
    end
    cfg(2'b01, 2'b01, 3'd3, 3'd1, 8'h40, 8'h40);
    repeat (4) @(posedge clk_sys);
    chk(oan, 1'b1);
    chk(obn, 1'b1);
    cfg(2'b01, 2'b01, 3'd7, 3'd1, 8'h40, 8'h40);
    repeat (4) @(posedge clk_sys);
    chk(oan, 1'b0);
    chk(obn, 1'b1);
    wr(`ATPWC_OFS_ASYNC_STAT, 8'h01);
    #1;
    chk(osc_detach, 1'b1);
    @(posedge clk_sys);
    rd(`ATPWC_OFS_ASYNC_STAT, d);
    chk(d, 8'h01);
    xtal_on <= 1'b1;
    cfg(2'b01, 2'b00, 3'd2, 3'd1, 8'h00, 8'h00);
    gap(0, f, n);
    chk(n, 10);
    xtal_on <= 1'b0;
    wr(`ATPWC_OFS_ASYNC_STAT, 8'h00);
    #1;
    chk(osc_detach, 1'b0);
    complete_run;
  end
endmodule
`default_nettype wire
